//--- common/blend_pkg.sv
package blend_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus shape
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam int          IDX_W         = 10;

  ////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [9:0]  IDX_L0_KEY    = 10'h0bc;
  localparam logic [9:0]  IDX_L3_KEY    = 10'h0c0;
  localparam logic [9:0]  IDX_L2_KEY    = 10'h0c2;
  localparam logic [9:0]  IDX_L4_BLEND  = 10'h194;
  localparam logic [9:0]  IDX_L5_BLEND  = 10'h198;
  localparam logic [9:0]  IDX_L0_EXT    = 10'h1a0;
  localparam logic [9:0]  IDX_L2_EXT    = 10'h1a8;
  localparam logic [9:0]  IDX_L3_EXT    = 10'h1ac;

  ////////////////////////////////////////////////////////////////////////////
  // blend register fields
  localparam int          RATIO_W       = 8;
  localparam int          PLANE_BIT     = 13;
  localparam int          INC_BIT       = 14;
  localparam int          EQ_BIT        = 15;
  localparam int          ON_BIT        = 16;
  localparam logic [8:0]  RATIO_ONE     = 9'h100;
  localparam logic [7:0]  RATIO_RESET   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // key colour register fields
  localparam int          KEY_W         = 15;
  localparam int          EXT_KEY_W     = 24;
  localparam int          ZERO_BIT      = 15;
  localparam int          EXT_ZERO_BIT  = 31;
  localparam int          INDIRECT_W    = 8;
  localparam logic [23:0] KEY_RESET     = 24'h000000;

  ////////////////////////////////////////////////////////////////////////////
  // pixel formats seen by the key compare
  typedef enum logic [1:0] {
    PIX_INDIRECT8,
    PIX_DIRECT16,
    PIX_DIRECT24
  } pix_mode_t;

endpackage

//--- core/key_match.sv
module key_match (
  // programmed key
  input  wire logic [23:0]          key,
  input  wire logic                 zero_opaque,
  // pixel under test
  input  wire logic [23:0]          code,
  input  wire blend_pkg::pix_mode_t mode,
  // result
  output logic                      hit
);
  import blend_pkg::*;

  logic key_eq;
  logic code_zero;

  ////////////////////////////////////////////////////////////////////////////
  // compare only the bits that the pixel format carries
  always_comb begin
    case (mode)
      PIX_INDIRECT8: begin
        key_eq    = (code[INDIRECT_W-1:0] == key[INDIRECT_W-1:0]); // (R9)
        code_zero = (code[INDIRECT_W-1:0] == '0);
      end
      PIX_DIRECT16: begin
        key_eq    = (code[KEY_W-1:0] == key[KEY_W-1:0]); // (R8)
        code_zero = (code[KEY_W-1:0] == '0);
      end
      PIX_DIRECT24: begin
        key_eq    = (code == key);
        code_zero = (code == '0);
      end
      default: begin
        key_eq    = 1'b0;
        code_zero = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // code zero is see-through unless marked opaque; zero key with zero bit
  // clear lands here too, showing black as transparent
  always_comb begin
    if (code_zero) begin
      hit = ~zero_opaque; // (R10) (R11)
    end else begin
      hit = key_eq; // (R8)
    end
  end

endmodule

//--- core/layer_blend_transparency.sv
// How it works
// (R1) eight-bit ratio field means value over 256
// (R2) layer 4 ratio may come from layer 5
// (R3) increment adds one step to nonzero ratio
// (R4) equation bit swaps upper and lower weights
// (R5) blend-on selects blending, else key overlay
// (R6) software enables blend bit and pixel alpha
// (R7) alpha flag from pixel or palette MSB
// (R8) code equal to key colour is transparent
// (R9) eight-bit indirect compares low eight bits
// (R10) zero bit decides whether code zero shows
// (R11) zero key and bit give transparent black
// (R12) layer 0 key also applies when blending
// (R13) short key registers alias extended registers
// (R14) reserved bits read zero, ignore writes
//
// Our own choice: the APB register port.
module layer_blend_transparency (
  // clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // apb slave
  input  wire logic [blend_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [blend_pkg::DATA_W-1:0]  pwdata,
  output logic      [blend_pkg::DATA_W-1:0]  prdata,
  output logic                               pready,
  output logic                               pslverr,
  // key pixels, index 0 1 2 for layers 0 2 3
  input  wire logic                          key_valid,
  input  wire logic [23:0]                   key_code [3],
  input  wire blend_pkg::pix_mode_t          key_mode [3],
  input  wire logic [2:0]                    key_layer_blending,
  output logic                               key_out_valid,
  output logic      [2:0]                    key_transparent,
  // blend pixels, index 0 1 for layers 4 5
  input  wire logic                          blend_valid,
  input  wire logic [23:0]                   blend_upper [2],
  input  wire logic [23:0]                   blend_lower [2],
  input  wire logic [1:0]                    upper_data_msb,
  input  wire logic [1:0]                    upper_palette_msb,
  input  wire logic [1:0]                    upper_indirect,
  input  wire logic [7:0]                    layer5_pixel_ratio,
  output logic                               blend_out_valid,
  output logic      [23:0]                   blend_rgb [2],
  output logic      [1:0]                    blend_applied
);
  import blend_pkg::*;

  localparam logic [IDX_W-1:0] KEY_IDX   [3] = '{IDX_L0_KEY, IDX_L2_KEY, IDX_L3_KEY};
  localparam logic [IDX_W-1:0] EXT_IDX   [3] = '{IDX_L0_EXT, IDX_L2_EXT, IDX_L3_EXT};
  localparam logic [IDX_W-1:0] BLEND_IDX [2] = '{IDX_L4_BLEND, IDX_L5_BLEND};

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0]       ratio [2];
  logic [1:0]       ratio_inc;
  logic [1:0]       eq_sel;
  logic [1:0]       blend_on;
  logic             plane_sel;
  logic [23:0]      key [3];
  logic [2:0]       zero_opaque;

  logic [IDX_W-1:0] idx;
  logic             setup;
  logic             wr;
  logic [31:0]      rd_mux;
  logic             mapped;

  assign idx    = paddr[ADDR_W-1:2];
  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pwrite;
  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rd_mux = '0;
    mapped = 1'b0;
    for (int k = 0; k < 3; k++) begin
      if (idx == KEY_IDX[k]) begin
        rd_mux = {16'h0000, zero_opaque[k], key[k][KEY_W-1:0]}; // (R13)
        mapped = 1'b1;
      end
      if (idx == EXT_IDX[k]) begin
        rd_mux = {zero_opaque[k], 7'h00, key[k]}; // (R13)
        mapped = 1'b1;
      end
    end
    for (int b = 0; b < 2; b++) begin
      if (idx == BLEND_IDX[b]) begin
        rd_mux[RATIO_W-1:0] = ratio[b]; // (R14)
        rd_mux[PLANE_BIT]   = (b == 0) ? plane_sel : 1'b0;
        rd_mux[INC_BIT]     = ratio_inc[b];
        rd_mux[EQ_BIT]      = eq_sel[b];
        rd_mux[ON_BIT]      = blend_on[b];
        mapped              = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer, captured in the setup cycle, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? '0 : rd_mux;
      pslverr <= ~mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // blend parameter registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio     <= '{RATIO_RESET, RATIO_RESET};
      ratio_inc <= '0;
      eq_sel    <= '0;
      blend_on  <= '0;
      plane_sel <= 1'b0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (wr && idx == BLEND_IDX[b]) begin
          ratio[b]     <= pwdata[RATIO_W-1:0]; // (R1)
          ratio_inc[b] <= pwdata[INC_BIT];
          eq_sel[b]    <= pwdata[EQ_BIT];
          blend_on[b]  <= pwdata[ON_BIT];
        end
      end
      if (wr && idx == IDX_L4_BLEND) begin
        plane_sel <= pwdata[PLANE_BIT]; // (R2)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key colour registers, short and extended views share storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key         <= '{KEY_RESET, KEY_RESET, KEY_RESET};
      zero_opaque <= '0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (wr && idx == KEY_IDX[k]) begin
          key[k][KEY_W-1:0] <= pwdata[KEY_W-1:0]; // (R13)
          zero_opaque[k]    <= pwdata[ZERO_BIT];
        end else if (wr && idx == EXT_IDX[k]) begin
          key[k]            <= pwdata[EXT_KEY_W-1:0]; // (R13)
          zero_opaque[k]    <= pwdata[EXT_ZERO_BIT];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transparency key per layer
  logic [2:0] hit;
  logic [2:0] next_transparent;

  for (genvar k = 0; k < 3; k++) begin : g_key
    key_match u_match (
      .key         (key[k]),
      .zero_opaque (zero_opaque[k]),
      .code        (key_code[k]),
      .mode        (key_mode[k]),
      .hit         (hit[k])
    );
    // layer 0 keeps its key in blend mode, the others drop it
    assign next_transparent[k] = hit[k] & ((k == 0) | ~key_layer_blending[k]); // (R12)
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_out_valid   <= 1'b0;
      key_transparent <= '0;
    end else begin
      key_out_valid   <= key_valid;
      key_transparent <= key_valid ? next_transparent : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // blend datapath for layers 4 and 5
  logic [1:0]      alpha;
  logic [1:0]      apply;
  logic [1:0][8:0] eff;
  logic [1:0][8:0] w_up;
  logic [1:0][8:0] w_lo;
  logic [23:0]     next_rgb [2];

  for (genvar b = 0; b < 2; b++) begin : g_blend
    logic [7:0] raw;
    assign alpha[b] = upper_indirect[b] ? upper_palette_msb[b] : upper_data_msb[b]; // (R7)
    // blending needs both the enable and the pixel alpha
    assign apply[b] = blend_on[b] & alpha[b]; // (R5) (R6)
    assign raw      = (b == 0 && plane_sel) ? layer5_pixel_ratio : ratio[b]; // (R2)
    assign eff[b]   = (ratio_inc[b] && raw != 8'h00) ? {1'b0, raw} + 9'h001
                                                    : {1'b0, raw}; // (R3)
    assign w_up[b]  = eq_sel[b] ? RATIO_ONE - eff[b] : eff[b]; // (R4)
    assign w_lo[b]  = RATIO_ONE - w_up[b]; // (R1)
    for (genvar c = 0; c < 3; c++) begin : g_chan
      logic [17:0] sum;
      assign sum = {10'h000, blend_upper[b][8*c +: 8]} * {9'h000, w_up[b]}
                 + {10'h000, blend_lower[b][8*c +: 8]} * {9'h000, w_lo[b]};
      assign next_rgb[b][8*c +: 8] = apply[b] ? sum[15:8] : blend_upper[b][8*c +: 8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blend_out_valid <= 1'b0;
      blend_rgb       <= '{24'h000000, 24'h000000};
      blend_applied   <= '0;
    end else begin
      blend_out_valid <= blend_valid;
      if (blend_valid) begin
        blend_rgb     <= next_rgb;
        blend_applied <= apply;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ext0_write;
    psel && penable && pwrite && idx == IDX_L0_EXT;
  endsequence

  sequence blend5_read;
    psel && penable && !pwrite && idx == IDX_L5_BLEND;
  endsequence

  sequence blend5_write;
    psel && penable && pwrite && idx == IDX_L5_BLEND;
  endsequence

  sequence l4_write;
    psel && penable && pwrite && idx == IDX_L4_BLEND;
  endsequence

  sequence l4_read;
    psel && penable && !pwrite && idx == IDX_L4_BLEND;
  endsequence

  sequence l2_short_write;
    psel && penable && pwrite && idx == IDX_L2_KEY;
  endsequence

  ratio_plain_a: assert property ( // (R1)
    !ratio_inc[1] |-> eff[1] == {1'b0, ratio[1]} && w_lo[1] == RATIO_ONE - w_up[1])
    else $error("layer 5 ratio differs from its field");

  plane_pick_a: assert property ( // (R2)
    plane_sel && !ratio_inc[0] |-> eff[0] == {1'b0, layer5_pixel_ratio})
    else $error("layer 4 ratio not taken from layer 5 pixel");

  ratio_step_a: assert property ( // (R3)
    ratio_inc[1] |-> eff[1] == ((ratio[1] == 8'h00) ? 9'h000 : {1'b0, ratio[1]} + 9'h001))
    else $error("increment applied wrongly");

  eq_swap_a: assert property ( // (R4)
    blend_valid && apply[1] && eff[1] == RATIO_ONE
    |=> blend_rgb[1] == ($past(eq_sel[1]) ? $past(blend_lower[1]) : $past(blend_upper[1])))
    else $error("blend equation select wrong");

  keyed_pass_a: assert property ( // (R5)
    blend_valid && !blend_on[1] |=> !blend_applied[1] && blend_rgb[1] == $past(blend_upper[1]))
    else $error("layer blended while blend is off");

  alpha_src_a: assert property ( // (R7)
    blend_valid && blend_on[0] && upper_indirect[0]
    |=> blend_applied[0] == $past(upper_palette_msb[0]))
    else $error("alpha flag taken from wrong source");

  key_hit_a: assert property ( // (R8)
    key_valid && key_mode[1] == PIX_DIRECT16 && key_code[1][14:0] == key[1][14:0]
    && key_code[1][14:0] != 15'h0000 && !key_layer_blending[1]
    |=> key_transparent[1] && key_out_valid)
    else $error("matching code not transparent");

  low_byte_a: assert property ( // (R9)
    key_valid && key_mode[2] == PIX_INDIRECT8 && key_code[2][7:0] != 8'h00
    && !key_layer_blending[2] |=> key_transparent[2] == ($past(key[2][7:0]) == $past(key_code[2][7:0])))
    else $error("indirect compare not on low byte");

  zero_code_a: assert property ( // (R10) (R11)
    key_valid && key_mode[0] == PIX_DIRECT24 && key_code[0] == 24'h000000
    |=> key_transparent[0] == !$past(zero_opaque[0]))
    else $error("code zero handled wrongly");

  l0_blend_a: assert property ( // (R12)
    key_valid && key_layer_blending[0] && hit[0] |=> key_transparent[0])
    else $error("layer 0 key lost in blend mode");

  alias_a: assert property ( // (R13)
    ext0_write |=> key[0][14:0] == $past(pwdata[14:0]) && zero_opaque[0] == $past(pwdata[31]))
    else $error("extended write not seen in short register");

  reserved_a: assert property ( // (R14)
    blend5_read |-> prdata[31:17] == 15'h0000 && prdata[13:8] == 6'h00)
    else $error("reserved bits not zero");

  l4_fields_a: assert property ( // (R1) (R2)
    l4_write |=> ratio[0] == $past(pwdata[RATIO_W-1:0])
    && plane_sel == $past(pwdata[PLANE_BIT]))
    else $error("layer 4 blend write did not land");

  l5_fields_a: assert property ( // (R3) (R4) (R5)
    blend5_write |=> ratio_inc[1] == $past(pwdata[INC_BIT])
    && eq_sel[1] == $past(pwdata[EQ_BIT]) && blend_on[1] == $past(pwdata[ON_BIT]))
    else $error("layer 5 blend write did not land");

  l4_reserved_a: assert property ( // (R14)
    l4_read |-> prdata[31:17] == 15'h0000 && prdata[12:8] == 5'h00)
    else $error("layer 4 reserved bits not zero");

  short_alias_a: assert property ( // (R13)
    l2_short_write |=> key[1][14:0] == $past(pwdata[14:0])
    && zero_opaque[1] == $past(pwdata[ZERO_BIT])
    && key[1][23:15] == $past(key[1][23:15]))
    else $error("short write disturbed extended view");

  key_gate_a: assert property ( // (R12)
    key_valid && key_layer_blending[2] |=> !key_transparent[2])
    else $error("layer 3 keyed while blending");

  idle_key_a: assert property ( // (R8)
    !key_valid |=> !key_out_valid && key_transparent == 3'b000)
    else $error("key result without a pixel");

  direct_hit_a: assert property ( // (R8)
    key_valid && key_mode[0] == PIX_DIRECT24 && key_code[0] == key[0]
    && key_code[0] != 24'h000000 |=> key_transparent[0])
    else $error("full-width key match missed");

  zero_ratio_a: assert property ( // (R3) (R4)
    blend_valid && apply[1] && eff[1] == 9'h000 && !eq_sel[1]
    |=> blend_rgb[1] == $past(blend_lower[1]))
    else $error("zero ratio did not pass lower layer");

  l4_off_a: assert property ( // (R5)
    blend_valid && !blend_on[0] |=> !blend_applied[0] && blend_rgb[0] == $past(blend_upper[0]))
    else $error("layer 4 blended while blend is off");

  no_alpha_a: assert property ( // (R7)
    blend_valid && !upper_indirect[1] && !upper_data_msb[1] |=> !blend_applied[1])
    else $error("layer 5 blended without pixel alpha");

  plane_off_a: assert property ( // (R2)
    !plane_sel && !ratio_inc[0] |-> eff[0] == {1'b0, ratio[0]})
    else $error("layer 4 ratio not taken from its field");

endmodule

//--- dv/tb.sv
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin bad_count++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import blend_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // signals
  logic                 pclk = 1'b0;
  logic                 presetn = 1'b0;
  logic [ADDR_W-1:0]    paddr;
  logic                 psel, penable, pwrite, pready, pslverr;
  logic [DATA_W-1:0]    pwdata, prdata;
  logic                 key_valid, key_out_valid, blend_valid, blend_out_valid;
  logic [23:0]          kc [3];
  pix_mode_t            km [3];
  logic [2:0]           kbl, key_transparent, ke;
  logic [23:0]          bu [2];
  logic [23:0]          bl [2];
  logic [23:0]          blend_rgb [2];
  logic [1:0]           dmsb, pmsb, ind, blend_applied;
  logic [7:0]           l5r;
  int                   bad_count = 0;
  int                   check_count = 0;
  int                   cyc = 0;
  logic [31:0]          seed = 32'd24;
  logic [31:0]          rv;
  logic [23:0]          key24 [3];
  logic                 zb [3];
  logic [31:0]          bm [2];
  logic [32:0]          aq [$];
  logic [32:0]          ae;
  logic [2:0]           kq [$];
  logic [49:0]          bq [$];
  logic [49:0]          be;
  localparam logic [9:0]  sidx [3] = '{IDX_L0_KEY, IDX_L2_KEY, IDX_L3_KEY};
  localparam logic [9:0]  eidx [3] = '{IDX_L0_EXT, IDX_L2_EXT, IDX_L3_EXT};
  localparam logic [9:0]  bidx [2] = '{IDX_L4_BLEND, IDX_L5_BLEND};
  localparam logic [31:0] bmask [2] = '{32'h0001e0ff, 32'h0001c0ff};

  always #50 pclk = ~pclk;

  layer_blend_transparency u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_valid(key_valid), .key_code(kc), .key_mode(km), .key_layer_blending(kbl),
    .key_out_valid(key_out_valid), .key_transparent(key_transparent),
    .blend_valid(blend_valid), .blend_upper(bu), .blend_lower(bl), .upper_data_msb(dmsb),
    .upper_palette_msb(pmsb), .upper_indirect(ind), .layer5_pixel_ratio(l5r),
    .blend_out_valid(blend_out_valid), .blend_rgb(blend_rgb), .blend_applied(blend_applied)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [11:0] ba(input logic [9:0] i);
    return {i, 2'b00};
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] ex);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    aq.push_back(ex);
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr_short(input int i, input logic [31:0] v);
    key24[i][14:0] = v[14:0];
    zb[i] = v[15];
    xfer(1'b1, ba(sidx[i]), v, 33'h0);
  endtask

  task automatic wr_ext(input int i, input logic [31:0] v);
    key24[i] = v[23:0];
    zb[i] = v[31];
    xfer(1'b1, ba(eidx[i]), v, 33'h0);
  endtask

  task automatic wr_blend(input int j, input logic [31:0] v);
    bm[j] = v & bmask[j];
    xfer(1'b1, ba(bidx[j]), v, 33'h0);
  endtask

  task automatic check_regs();
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, ba(sidx[i]), 32'h0, {17'h0, zb[i], key24[i][14:0]});
      xfer(1'b0, ba(eidx[i]), 32'h0, {1'b0, zb[i], 7'h0, key24[i]});
    end
    for (int j = 0; j < 2; j++) xfer(1'b0, ba(bidx[j]), 32'h0, {1'b0, bm[j]});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // pixel driver, notes expected results
  task automatic pixels(input int n);
    logic [31:0] r;
    logic [23:0] c, m;
    logic [23:0] u [2];
    logic [23:0] lw [2];
    logic [23:0] o [2];
    logic [2:0]  kt, blv;
    logic [1:0]  ap, dm, pm, id;
    logic [8:0]  rt, wu;
    logic [7:0]  rr, l5;
    pix_mode_t   md;
    int          a, b, t;
    for (int k = 0; k < n; k++) begin
      @(posedge pclk);
      r = rnd();
      blv = r[2:0];
      for (int i = 0; i < 3; i++) begin
        r = rnd();
        case (r[1:0])
          2'd0: c = {r[31:16], key24[i][7:0]};
          2'd1: c = 24'h0;
          2'd2: c = key24[i];
          default: c = r[31:8];
        endcase
        md = pix_mode_t'(2'(r[7:2] % 3));
        m = (md == PIX_INDIRECT8) ? 24'hff : (md == PIX_DIRECT16) ? 24'h7fff : 24'hffffff;
        kt[i] = ((c & m) == 24'h0) ? !zb[i] : (((c ^ key24[i]) & m) == 24'h0);
        if (i > 0 && blv[i]) kt[i] = 1'b0;
        kc[i] <= c;
        km[i] <= md;
      end
      r = rnd();
      l5 = r[7:0]; dm = r[9:8]; pm = r[11:10]; id = r[13:12];
      for (int j = 0; j < 2; j++) begin
        r = rnd();
        u[j] = r[23:0];
        r = rnd();
        lw[j] = r[23:0];
        rr = (j == 0 && bm[0][13]) ? l5 : bm[j][7:0];
        rt = {1'b0, rr} + ((bm[j][14] && rr != 8'h0) ? 9'd1 : 9'd0);
        wu = bm[j][15] ? 9'h100 - rt : rt;
        ap[j] = bm[j][16] & (id[j] ? pm[j] : dm[j]);
        for (int ch = 0; ch < 3; ch++) begin
          a = u[j][8*ch +: 8];
          b = lw[j][8*ch +: 8];
          t = (a * int'(wu) + b * (256 - int'(wu))) >> 8;
          o[j][8*ch +: 8] = ap[j] ? t[7:0] : u[j][8*ch +: 8];
        end
        bu[j] <= u[j];
        bl[j] <= lw[j];
      end
      kbl <= blv; key_valid <= 1'b1; kq.push_back(kt);
      dmsb <= dm; pmsb <= pm; ind <= id; l5r <= l5; blend_valid <= 1'b1;
      bq.push_back({ap, o[0], o[1]});
    end
    @(posedge pclk);
    key_valid <= 1'b0;
    blend_valid <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // output watcher
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      give_verdict();
    end
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      ae = aq.pop_front();
      `CHK("apb", ae, {pslverr, prdata})
    end
    if (key_out_valid === 1'b1) begin
      ke = kq.pop_front();
      `CHK("transparent", ke, key_transparent)
    end
    if (blend_out_valid === 1'b1) begin
      be = bq.pop_front();
      `CHK("applied", be[49:48], blend_applied)
      `CHK("rgb4", be[47:24], blend_rgb[0])
      `CHK("rgb5", be[23:0], blend_rgb[1])
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    paddr = '0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; pwdata = '0;
    key_valid = 1'b0; kbl = 3'h0; blend_valid = 1'b0;
    dmsb = 2'h0; pmsb = 2'h0; ind = 2'h0; l5r = 8'h00;
    for (int i = 0; i < 3; i++) begin
      kc[i] = 24'h0; km[i] = PIX_INDIRECT8; key24[i] = 24'h0; zb[i] = 1'b0;
    end
    for (int j = 0; j < 2; j++) begin
      bu[j] = 24'h0; bl[j] = 24'h0; bm[j] = 32'h0;
    end
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    check_regs();
    xfer(1'b1, 12'hffc, 32'hffffffff, {1'b1, 32'h0});
    xfer(1'b0, 12'hffc, 32'h0, {1'b1, 32'h0});
    wr_blend(0, 32'hffffffff);
    wr_blend(1, 32'hffffffff);
    wr_ext(0, 32'h80abcdef);
    wr_short(0, 32'hffff1234);
    check_regs();
    pixels(20);
    for (int n = 0; n < 10; n++) begin
      for (int i = 0; i < 3; i++) begin
        rv = rnd();
        if (rv[3:0] == 4'h0) rv = 32'h0;
        if (rv[4]) wr_ext(i, rv);
        else wr_short(i, rv);
      end
      for (int j = 0; j < 2; j++) wr_blend(j, (n % 3 == 1) ? (rnd() & 32'hffffff00) : rnd());
      check_regs();
      pixels(40);
    end
    repeat (4) @(posedge pclk);
    `CHK("pending", 0, aq.size() + kq.size() + bq.size())
    give_verdict();
  end
endmodule
